/* File: include/timer2_ctl_map.svh */
// register offsets, field positions, reset values and counts of the timer2 control slice
// assumes an 8-bit data-space address and 8-bit data bus
`ifndef TIMER2_CTL_MAP_SVH
`define TIMER2_CTL_MAP_SVH

`define T2_EVENT_FLAGS_OFS 8'h37
`define T2_SYNC_PRESC_OFS 8'h43
`define T2_ASYNC_STATUS_OFS 8'hb6
`define T2_CONTROL_A_OFS 8'hb0
`define T2_CONTROL_B_OFS 8'hb1
`define T2_COUNTER_OFS 8'hb2
`define T2_COMPARE_A_OFS 8'hb3
`define T2_COMPARE_B_OFS 8'hb4

`define T2_IO_SHIFT 8'h20
`define T2_IO_TOP 8'h3f

`define T2_FLAG_OVF 0
`define T2_FLAG_CMPA 1
`define T2_FLAG_CMPB 2

`define T2_GT_SYNC_MODE 7
`define T2_GT_ASYNC_PR 1
`define T2_GT_SHARED_PR 0

`define T2_AS_EXT_CLK 6
`define T2_AS_ASYNC_SEL 5
`define T2_BUSY_COUNTER 4
`define T2_BUSY_CMPA 3
`define T2_BUSY_CMPB 2
`define T2_BUSY_CTLA 1
`define T2_BUSY_CTLB 0

`define T2_FLAGS_RST 3'h0
`define T2_BUSY_RST 5'h00
`define T2_RDATA_RST 8'h00

// async clock edges a written value needs to pass the synchroniser
`define T2_XFER_EDGES 2'h2

`endif

/* File: include/timer2_ctl_pkg.sv */
// types shared by the timer2 flag, async-clock and prescaler control slice
// constants live in timer2_ctl_map.svh
package timer2_ctl_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic ioSpace;
  } reg_bus_req_t;

  typedef struct packed {
    logic compareB;
    logic compareA;
    logic overflow;
  } timer_events_t;

  typedef enum logic [0:0] {
    PR_IDLE = 1'b0,
    PR_WAIT_ASYNC = 1'b1
  } async_pr_state_t;

endpackage : timer2_ctl_pkg

/* File: src/osc_pin_sync.sv */
// three-flop synchroniser for the oscillator input pin with rising-edge pulse
// assumes the pin is unrelated to clk; a change counts once flops two and three agree
`timescale 1ns/100ps
module osc_pin_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pinIn,
  output logic risePulse
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic rise_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pinIn;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      rise_ff <= 1'b0;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
        rise_ff <= s3_ff & ~level_ff;
      end
    end
  end

  assign risePulse = rise_ff;

endmodule : osc_pin_sync

/* File: src/update_busy_tracker.sv */
// update-busy flags for the five asynchronously updated timer registers
// assumes asyncTick pulses once per synchronised async clock edge
`timescale 1ns/100ps
`include "timer2_ctl_map.svh"
module update_busy_tracker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic asyncMode,
  input wire logic asyncTick,
  input wire logic [4:0] regWrite,
  output logic [4:0] busy,
  output logic [4:0] updateDone
);

  logic [4:0] busy_ff;
  logic [4:0] done_ff;
  logic [1:0] edgeCnt_ff [5];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff <= `T2_BUSY_RST;
      done_ff <= 5'h00;
      for (int i = 0; i < 5; i++) begin
        edgeCnt_ff[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        done_ff[i] <= 1'b0;
        if (regWrite[i] && asyncMode) begin
          // a fresh write restarts the crossing and beats a finishing one
          busy_ff[i] <= 1'b1;
          edgeCnt_ff[i] <= 2'h0;
        end else if (busy_ff[i] && asyncTick) begin
          if (edgeCnt_ff[i] == `T2_XFER_EDGES - 2'h1) begin
            busy_ff[i] <= 1'b0;
            done_ff[i] <= 1'b1;
            edgeCnt_ff[i] <= 2'h0;
          end else begin
            edgeCnt_ff[i] <= edgeCnt_ff[i] + 2'h1;
          end
        end
      end
    end
  end

  assign busy = busy_ff;
  assign updateDone = done_ff;

endmodule : update_busy_tracker

/* File: src/timer2_flags_async_prescaler_ctl.sv */
// timer2 event flags, async clock status and prescaler reset control
// assumes counter logic supplies clk-domain event pulses and the cpu bus is clk-synchronous
`timescale 1ns/100ps
`include "timer2_ctl_map.svh"
module timer2_flags_async_prescaler_ctl (
  input wire logic clk,
  input wire logic reset_n,
  input timer2_ctl_pkg::reg_bus_req_t busReq,
  output logic [7:0] readData,
  input timer2_ctl_pkg::timer_events_t events,
  input wire logic pwmMode,
  input wire logic bottomReversal,
  input wire logic [2:0] vectorTaken,
  input wire logic globalIrqEnable,
  input wire logic [2:0] irqEnable,
  output logic [2:0] irqRequest,
  input wire logic oscPin,
  output logic crystalEnable,
  output logic extClockBufEnable,
  output logic asyncClockSelect,
  output logic timerTick,
  output logic [4:0] updateBusy,
  output logic [4:0] updateDone,
  output logic asyncPrescalerReset,
  output logic sharedPrescalerReset
);

  // io-space accesses map back onto data-space offsets
  function automatic logic [7:0] dataAddr(input timer2_ctl_pkg::reg_bus_req_t req);
    if (req.ioSpace) begin
      if (req.addr <= `T2_IO_TOP) begin
        dataAddr = req.addr + `T2_IO_SHIFT;
      end else begin
        dataAddr = 8'hff;
      end
    end else begin
      dataAddr = req.addr;
    end
  endfunction : dataAddr

  logic [7:0] effAddr;
  logic wrFlags;
  logic wrSync;
  logic wrStatus;
  logic [4:0] asyncRegWrite;
  logic overflowEvent;
  logic [2:0] flagSet;
  logic [2:0] flagClr;
  logic oscRise;
  logic asyncTick;
  logic [4:0] busyVec;
  logic [4:0] doneVec;

  logic [2:0] flags_ff;
  logic [2:0] nxt_flags;
  logic [2:0] irq_ff;
  logic [7:0] rdata_ff;
  logic extClk_ff;
  logic asyncSel_ff;
  logic crystal_ff;
  logic extBuf_ff;
  logic tick_ff;
  logic syncMode_ff;
  logic asyncPr_ff;
  logic sharedPr_ff;
  timer2_ctl_pkg::async_pr_state_t prState_ff;

  assign effAddr = dataAddr(busReq);
  assign wrFlags = busReq.wr && (effAddr == `T2_EVENT_FLAGS_OFS);
  assign wrSync = busReq.wr && (effAddr == `T2_SYNC_PRESC_OFS);
  assign wrStatus = busReq.wr && (effAddr == `T2_ASYNC_STATUS_OFS);

  always_comb begin
    asyncRegWrite = 5'h00;
    asyncRegWrite[`T2_BUSY_COUNTER] = busReq.wr && (effAddr == `T2_COUNTER_OFS);
    asyncRegWrite[`T2_BUSY_CMPA] = busReq.wr && (effAddr == `T2_COMPARE_A_OFS);
    asyncRegWrite[`T2_BUSY_CMPB] = busReq.wr && (effAddr == `T2_COMPARE_B_OFS);
    asyncRegWrite[`T2_BUSY_CTLA] = busReq.wr && (effAddr == `T2_CONTROL_A_OFS);
    asyncRegWrite[`T2_BUSY_CTLB] = busReq.wr && (effAddr == `T2_CONTROL_B_OFS);
  end

  // event flags
  // in pwm the counter never wraps, so the bottom turn stands in for it
  assign overflowEvent = pwmMode ? bottomReversal : events.overflow;

  always_comb begin
    flagSet = 3'h0;
    flagSet[`T2_FLAG_CMPB] = events.compareB;
    flagSet[`T2_FLAG_CMPA] = events.compareA;
    flagSet[`T2_FLAG_OVF] = overflowEvent;
    flagClr = vectorTaken;
    if (wrFlags) begin
      flagClr = flagClr | busReq.wdata[2:0];
    end
    // a set landing with a clear is kept
    nxt_flags = (flags_ff & ~flagClr) | flagSet;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= `T2_FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ff <= 3'h0;
    end else begin
      irq_ff <= {3{globalIrqEnable}} & irqEnable & nxt_flags;
    end
  end

  // async clock status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extClk_ff <= 1'b0;
      asyncSel_ff <= 1'b0;
    end else if (wrStatus) begin
      extClk_ff <= busReq.wdata[`T2_AS_EXT_CLK];
      asyncSel_ff <= busReq.wdata[`T2_AS_ASYNC_SEL];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crystal_ff <= 1'b1;
      extBuf_ff <= 1'b0;
    end else begin
      // crystal and external buffer are never on together
      crystal_ff <= ~extClk_ff;
      extBuf_ff <= extClk_ff & asyncSel_ff;
    end
  end

  osc_pin_sync u_osc_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pinIn(oscPin),
    .risePulse(oscRise)
  );

  // pin edges count only with async select on; otherwise every io clock ticks
  assign asyncTick = asyncSel_ff & oscRise;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= asyncSel_ff ? oscRise : 1'b1;
    end
  end

  update_busy_tracker u_busy (
    .clk(clk),
    .reset_n(reset_n),
    .asyncMode(asyncSel_ff),
    .asyncTick(asyncTick),
    .regWrite(asyncRegWrite),
    .busy(busyVec),
    .updateDone(doneVec)
  );

  // prescaler reset control
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncMode_ff <= 1'b0;
    end else if (wrSync) begin
      syncMode_ff <= busReq.wdata[`T2_GT_SYNC_MODE];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sharedPr_ff <= 1'b0;
    end else if (wrSync) begin
      if (busReq.wdata[`T2_GT_SYNC_MODE]) begin
        sharedPr_ff <= busReq.wdata[`T2_GT_SHARED_PR];
      end else begin
        // one-cycle pulse; a write that also drops sync mode clears it without a pulse
        sharedPr_ff <= busReq.wdata[`T2_GT_SHARED_PR] & ~syncMode_ff;
      end
    end else if (!syncMode_ff) begin
      sharedPr_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      asyncPr_ff <= 1'b0;
      prState_ff <= timer2_ctl_pkg::PR_IDLE;
    end else if (wrSync) begin
      if (busReq.wdata[`T2_GT_SYNC_MODE]) begin
        asyncPr_ff <= busReq.wdata[`T2_GT_ASYNC_PR];
        prState_ff <= timer2_ctl_pkg::PR_IDLE;
      end else if (syncMode_ff) begin
        asyncPr_ff <= 1'b0;
        prState_ff <= timer2_ctl_pkg::PR_IDLE;
      end else begin
        asyncPr_ff <= busReq.wdata[`T2_GT_ASYNC_PR];
        prState_ff <= (busReq.wdata[`T2_GT_ASYNC_PR] && asyncSel_ff) ?
                      timer2_ctl_pkg::PR_WAIT_ASYNC : timer2_ctl_pkg::PR_IDLE;
      end
    end else if (!syncMode_ff) begin
      unique case (prState_ff)
        timer2_ctl_pkg::PR_IDLE: begin
          asyncPr_ff <= 1'b0;
        end
        timer2_ctl_pkg::PR_WAIT_ASYNC: begin
          // held until an async edge has reset the prescaler or async select goes off
          if (asyncTick || !asyncSel_ff) begin
            asyncPr_ff <= 1'b0;
            prState_ff <= timer2_ctl_pkg::PR_IDLE;
          end
        end
      endcase
    end
  end

  // register read-back, one cycle after the read strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= `T2_RDATA_RST;
    end else if (busReq.rd) begin
      unique case (effAddr)
        `T2_EVENT_FLAGS_OFS: begin
          rdata_ff <= {5'h00, flags_ff};
        end
        `T2_SYNC_PRESC_OFS: begin
          rdata_ff <= {syncMode_ff, 5'h00, asyncPr_ff, sharedPr_ff};
        end
        `T2_ASYNC_STATUS_OFS: begin
          rdata_ff <= {1'b0, extClk_ff, asyncSel_ff, busyVec};
        end
        default: begin
          rdata_ff <= 8'h00;
        end
      endcase
    end
  end

  assign readData = rdata_ff;
  assign irqRequest = irq_ff;
  assign crystalEnable = crystal_ff;
  assign extClockBufEnable = extBuf_ff;
  assign asyncClockSelect = asyncSel_ff;
  assign timerTick = tick_ff;
  assign updateBusy = busyVec;
  assign updateDone = doneVec;
  assign asyncPrescalerReset = asyncPr_ff;
  assign sharedPrescalerReset = sharedPr_ff;

endmodule : timer2_flags_async_prescaler_ctl

/* File: tb/timer2_ctl_checker.sv */
// assertions on the timer2 flag, async clock and prescaler slice
// assumes it is bound to the slice's top module and sees its ports only
`timescale 1ns/100ps
module timer2_ctl_checker (
  input wire logic clk,
  input wire logic reset_n,
  input timer2_ctl_pkg::reg_bus_req_t busReq,
  input timer2_ctl_pkg::timer_events_t events,
  input wire logic pwmMode,
  input wire logic bottomReversal,
  input wire logic [2:0] vectorTaken,
  input wire logic globalIrqEnable,
  input wire logic [2:0] irqEnable,
  input wire logic [2:0] irqRequest,
  input wire logic crystalEnable,
  input wire logic extClockBufEnable,
  input wire logic asyncClockSelect,
  input wire logic [4:0] updateBusy,
  input wire logic sharedPrescalerReset
);
  logic wrCtl;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // prescaler control reached at either address
  assign wrCtl = busReq.wr && (busReq.ioSpace ? busReq.addr == 8'h23 : busReq.addr == 8'h43);
  property p_cmpb;
    events.compareB && globalIrqEnable && irqEnable[2] |=> irqRequest[2];
  endproperty
  a_cmpb: assert property (p_cmpb) else $error("compare-b request missing");
  property p_ovf;
    !pwmMode && events.overflow && globalIrqEnable && irqEnable[0] |=> irqRequest[0];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow request missing");
  property p_pwm;
    pwmMode && bottomReversal && globalIrqEnable && irqEnable[0] |=> irqRequest[0];
  endproperty
  a_pwm: assert property (p_pwm) else $error("bottom reversal request missing");
  property p_vec;
    vectorTaken[1] && !events.compareA |=> !irqRequest[1];
  endproperty
  a_vec: assert property (p_vec) else $error("vector did not clear flag");
  property p_irq;
    irqRequest != 3'h0 |-> (irqRequest & ~({3{$past(globalIrqEnable)}} & $past(irqEnable))) == 3'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("request without enables");
  property p_xtal;
    extClockBufEnable |-> !crystalEnable;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal runs with external clock");
  property p_busy;
    busReq.wr && !busReq.ioSpace && busReq.addr == 8'hb2 && asyncClockSelect |=> updateBusy[4];
  endproperty
  a_busy: assert property (p_busy) else $error("counter busy not set");
  property p_hold;
    wrCtl && busReq.wdata[7] && busReq.wdata[0] ##1 !wrCtl ##1 !wrCtl |-> sharedPrescalerReset;
  endproperty
  a_hold: assert property (p_hold) else $error("sync mode did not hold reset");
endmodule : timer2_ctl_checker

bind timer2_flags_async_prescaler_ctl timer2_ctl_checker chk_u (.*);

/* File: tb/timer2_flags_async_prescaler_ctl_test.sv */
// self-checking bench for the timer2 flag, async clock and prescaler slice
// assumes a clk-synchronous register bus; oscPin is paced from clk here
`timescale 1ns/100ps
module timer2_flags_async_prescaler_ctl_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  timer2_ctl_pkg::reg_bus_req_t busReq = '0;
  timer2_ctl_pkg::timer_events_t events = '0;
  logic pwmMode = 1'b0;
  logic bottomReversal = 1'b0;
  logic [2:0] vectorTaken = 3'h0;
  logic globalIrqEnable = 1'b0;
  logic [2:0] irqEnable = 3'h0;
  logic oscPin = 1'b0;
  logic [7:0] readData;
  logic [2:0] irqRequest;
  logic crystalEnable;
  logic extClockBufEnable;
  logic asyncClockSelect;
  logic [4:0] updateBusy;
  logic asyncPrescalerReset;
  logic sharedPrescalerReset;
  logic timerTick;
  logic [4:0] updateDone;
  logic [4:0] doneSeen;
  logic [7:0] busyBit [5] = '{8'h02, 8'h01, 8'h10, 8'h08, 8'h04};
  logic [7:0] k;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  int i;

  timer2_flags_async_prescaler_ctl dut_u (.*);

  always #5 clk = ~clk;

  // slow pin so each sync tick is well apart
  always @(posedge clk) begin
    cycles++;
    if (cycles % 4 == 0) oscPin <= ~oscPin;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'b0);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, ioSpace: io};
    @(posedge clk);
    busReq.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic io = 1'b0);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, ioSpace: io};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1;
    chk(readData, exp);
  endtask : rd

  task automatic ev(input logic [2:0] e, input logic [2:0] v, input logic b, input logic [2:0] m);
    @(posedge clk);
    events <= e;
    vectorTaken <= v;
    bottomReversal <= b;
    irqEnable <= m;
    @(posedge clk);
    events <= '0;
    vectorTaken <= 3'h0;
    bottomReversal <= 1'b0;
    #1;
  endtask : ev

  task automatic idle;
    i = 0;
    doneSeen = 5'h00;
    // sample off the edge; the done pulse stands one cycle only
    while (updateBusy !== 5'h00 && i < 200) begin
      @(posedge clk);
      #1;
      doneSeen = doneSeen | updateDone;
      i++;
    end
  endtask : idle

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    globalIrqEnable <= 1'b1;
    rd(8'h37, 8'h00);
    rd(8'h43, 8'h00);
    rd(8'hb6, 8'h00);
    rd(8'h37, 8'h00, 1'b1);
    for (k = 8'h00; k < 8'h03; k++) begin
      ev(3'h1 << k, 3'h0, 1'b0, 3'h7 ^ (3'h1 << k));
      chk({5'h0, irqRequest}, 8'h00);
      ev(3'h0, 3'h0, 1'b0, 3'h7);
      chk({5'h0, irqRequest}, 8'h1 << k);
      wr(8'h37, 8'h00);
      rd(8'h37, 8'h1 << k);
      ev(3'h1 << k, 3'h1 << k, 1'b0, 3'h7);
      rd(8'h37, 8'h1 << k);
      wr(8'h17, 8'h1 << k, 1'b1);
      rd(8'h37, 8'h00);
      ev(3'h1 << k, 3'h0, 1'b0, 3'h7);
      ev(3'h0, 3'h1 << k, 1'b0, 3'h7);
      rd(8'h37, 8'h00);
    end
    @(posedge clk) pwmMode <= 1'b1;
    ev(3'h1, 3'h0, 1'b0, 3'h7);
    rd(8'h37, 8'h00);
    ev(3'h0, 3'h0, 1'b1, 3'h7);
    rd(8'h37, 8'h01);
    wr(8'h37, 8'h01);
    @(posedge clk) pwmMode <= 1'b0;
    wr(8'hb6, 8'h40);
    wr(8'hb6, 8'hff);
    rd(8'hb6, 8'h60);
    chk({6'h0, crystalEnable, extClockBufEnable}, 8'h01);
    for (k = 8'h00; k < 8'h05; k++) begin
      wr(8'hb0 + k, 8'h00);
      rd(8'hb6, 8'h60 | busyBit[k]);
      idle();
      chk({3'h0, doneSeen}, busyBit[k]);
      rd(8'hb6, 8'h60);
    end
    wr(8'h43, 8'h02);
    chk({7'h0, asyncPrescalerReset}, 8'h01);
    i = 0;
    while (asyncPrescalerReset !== 1'b0 && i < 200) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk({7'h0, asyncPrescalerReset}, 8'h00);
    wr(8'hb6, 8'h40);
    wr(8'hb2, 8'h00);
    rd(8'hb6, 8'h40);
    chk({7'h0, timerTick}, 8'h01);
    chk({6'h0, crystalEnable, extClockBufEnable}, 8'h00);
    wr(8'h43, 8'h03);
    chk({6'h0, asyncPrescalerReset, sharedPrescalerReset}, 8'h03);
    @(posedge clk);
    #1;
    chk({6'h0, asyncPrescalerReset, sharedPrescalerReset}, 8'h00);
    wr(8'h23, 8'h83, 1'b1);
    rd(8'h43, 8'h83);
    chk({6'h0, asyncPrescalerReset, sharedPrescalerReset}, 8'h03);
    wr(8'h43, 8'h03);
    rd(8'h43, 8'h00);
    chk({6'h0, asyncPrescalerReset, sharedPrescalerReset}, 8'h00);
    print_verdict();
  end
endmodule : timer2_flags_async_prescaler_ctl_test
